// ==== core/counter_consts.vh ====
// Constants for the counter channel: offsets, fields, resets, timing
`ifndef COUNTER_CONSTS_VH
`define COUNTER_CONSTS_VH

// Register byte offsets
`define OFS_CTRL       6'h00
`define OFS_EVENT_EN   6'h04
`define OFS_CMP_VALUE  6'h08
`define OFS_PULSE_DUR  6'h0c
`define OFS_COUNT      6'h10
`define OFS_STATUS     6'h14

// Control fields
`define F_EVAL         1:0
`define F_HWGATE_EN    2
`define F_DIR_INV      3
`define F_OUT_CHAR     5:4
`define F_CMP_LE       6
`define F_MAIN_DIR     8:7
`define F_SOFTWARE_GATE      9
`define F_SW_OUT       10
`define F_IRQ_SEL      12:11
`define CTRL_W         13

// Event enable fields
`define F_EV_OPEN      0
`define F_EV_CLOSE     1
`define F_EV_CMP       2
`define F_EV_OFLW      3
`define F_EV_UFLW      4
`define EVENT_W        5

// Status fields
`define F_ST_CMP       0
`define F_ST_OFLW      1
`define F_ST_UFLW      2
`define F_ST_OUT       3
`define F_ST_GATE      4

// Encodings
`define EVAL_PULSE_DIR 2'h0
`define EVAL_SINGLE    2'h1
`define EVAL_DOUBLE    2'h2
`define EVAL_QUAD      2'h3
`define CHAR_NONE      2'h0
`define CHAR_CMP       2'h1
`define CHAR_PULSE     2'h2
`define MAIN_NONE      2'h0
`define MAIN_UP        2'h1
`define MAIN_DOWN      2'h2
`define IRQ_OFF        2'h0
`define IRQ_DIAG       2'h2

// Reset values
`define CTRL_RESET     13'h0000
`define EVENT_RESET    5'h00
`define CMP_RESET      32'h00000000
`define PDUR_RESET     8'h00
`define COUNT_RESET    32'h00000000

// Limits and timing
`define COUNT_MAX      32'h7fffffff
`define COUNT_MIN      32'h80000000
`define PULSE_STEP_US  2000
`define CLK_MHZ        250
`define PULSE_STEP_CYC (`PULSE_STEP_US * `CLK_MHZ)
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ==== core/track_decoder.v ====
// Input evaluation: pulse/direction or two-track encoder to count steps
`include "counter_consts.vh"

module track_decoder (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Configuration
  input  wire [1:0] eval_mode,
  input  wire       dir_invert,
  // Tracks
  input  wire       track_a,
  input  wire       track_b,
  // Result
  output reg        step,
  output reg        step_up
);

  reg a_q;  // Track A one cycle ago
  reg b_q;  // Track B one cycle ago

  // Previous track levels for edge detection
  always @(posedge aclk) begin
    if (!aresetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= track_a;
      b_q <= track_b;
    end
  end

  // Step and direction per evaluation mode
  always @* begin
    step    = 1'b0;
    step_up = 1'b0;
    case (eval_mode)
      `EVAL_PULSE_DIR: begin  // Rising pulse edge, direction level
        step    = track_a & ~a_q;
        step_up = track_b ^ dir_invert;
      end
      `EVAL_SINGLE: begin  // One step per track A period
        step    = track_a & ~a_q;
        step_up = ~track_b ^ dir_invert;
      end
      `EVAL_DOUBLE: begin  // Both track A edges
        step    = track_a ^ a_q;
        step_up = (track_a ^ track_b) ^ dir_invert;
      end
      `EVAL_QUAD: begin  // Every edge of both tracks
        step    = (track_a ^ a_q) | (track_b ^ b_q);
        step_up = (track_a ^ b_q) ^ dir_invert;
      end
      default: begin
        step    = 1'b0;
        step_up = 1'b0;
      end
    endcase
  end

endmodule // track_decoder

// ==== core/counter_channel.v ====
// Counter channel: input evaluation, gate, comparator output, events
//
// Operation
// - Pulse/direction or encoder x1/x2/x4, default pulse
// - Hardware gate option ANDs hardware and software gate
// - Optional inversion of direction signal
// - No comparison: software output, compare flag clear
// - Comparator sets output on >= or <=
// - Pulse mode: timed pulse on reaching value
// - Main direction restricts pulse to that direction
// - Pulse timing starts with output, within 1ms
// - Re-reaching value never retriggers running pulse
// - Duration change applies from next pulse
// - Zero duration holds output while value matches
// - Duration in 2ms steps, default zero
// - Gate rising edge raises process interrupt
// - Gate falling edge raises process interrupt
// - Comparator firing raises interrupt when enabled
// - Overflow raises interrupt when enabled
// - Underflow raises interrupt when enabled
// - Interrupt select off/process/diagnostics on loss
// - Sticky overflow/underflow flags until clear request
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`include "counter_consts.vh"

module counter_channel #(
  parameter STEP_CYCLES = `PULSE_STEP_CYC  // Cycles per 2ms duration step
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Encoder or pulse source, gate
  input  wire        track_a,
  input  wire        track_b,
  input  wire        hardware_gate_input,
  // Digital output and interrupts
  output reg         digital_out_q,
  output reg         process_irq_q,
  output reg         diag_irq_q,
  input  wire        process_irq_ack
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [`CTRL_W-1:0]  ctrl_q;       // Control register
  reg  [`EVENT_W-1:0] event_en_q;   // Event enables
  reg  [31:0]         cmp_value_q;  // Comparison value
  reg  [7:0]          pulse_dur_q;  // Duration in 2ms steps
  reg  [31:0]         count_q;      // Counter value
  reg  [31:0]         count_d;
  reg                 overflow_status_flag;
  reg                 underflow_status_flag;
  reg                 compare_status_flag;
  reg                 hardware_gate_input_q;    // Gate input one cycle ago
  reg                 aw_got_q;     // Write address held
  reg                 w_got_q;      // Write data held
  reg  [31:0]         awaddr_q;
  reg  [31:0]         wdata_q;
  reg  [3:0]          wstrb_q;
  reg                 pulse_run_q;  // Timed pulse in progress
  reg  [7:0]          pulse_left_q; // Steps remaining
  reg  [18:0]         pre_q;        // Cycles within one step
  reg                 hold_q;       // Zero-duration hold
  reg                 cmp_prev_q;   // Compare flag one cycle ago
  reg                 proc_pend_q;  // Process interrupt not yet taken
  reg                 out_d;
  reg                 cmp_flag_d;
  wire                step;
  wire                step_up;
  wire                software_gate;
  wire                gate_open;
  wire                wr_fire;
  wire                wr_status;
  wire                do_step;
  wire                oflw;
  wire                uflw;
  wire                reach;
  wire                cond;
  wire                ev_open;
  wire                ev_close;
  wire                ev_cmp;
  wire                proc_event;
  wire                pre_wrap;
  wire [31:0]         ctrl_wr;      // Control word merged with a write

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Byte-lane merge of a write into an old value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Address decode shared by read and write paths
  function mapped;
    input [31:0] addr;
    begin
      mapped = (addr[31:5] == 27'h0) && (addr[1:0] == 2'h0) &&
               (addr[4:2] <= 3'h5);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input evaluation and gate

  track_decoder u_dec (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .eval_mode  (ctrl_q[`F_EVAL]),
    .dir_invert (ctrl_q[`F_DIR_INV]),
    .track_a    (track_a),
    .track_b    (track_b),
    .step       (step),
    .step_up    (step_up)
  );

  assign software_gate = ctrl_q[`F_SOFTWARE_GATE];
  // Hardware gate counts only when the option is on
  assign gate_open = software_gate &
    (~ctrl_q[`F_HWGATE_EN] | hardware_gate_input);
  assign do_step = step & gate_open;
  assign oflw    = do_step & step_up & (count_q == `COUNT_MAX);
  assign uflw    = do_step & ~step_up & (count_q == `COUNT_MIN);

  ////////////////////////////////////////////////////////////////////////
  // Bus write path

  assign wr_fire   = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign wr_status = wr_fire & mapped(awaddr_q) &
                     (awaddr_q[5:0] == `OFS_STATUS);
  assign ctrl_wr   = merge({19'h0, ctrl_q}, wdata_q, wstrb_q);

  // Address and data taken in either order, answer after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 32'h00000000;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q      <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q      <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin  // Both halves present: answer
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= `CTRL_RESET;
      event_en_q  <= `EVENT_RESET;
      cmp_value_q <= `CMP_RESET;
      pulse_dur_q <= `PDUR_RESET;
    end else if (wr_fire && mapped(awaddr_q)) begin
      case (awaddr_q[5:0])
        `OFS_CTRL:
          ctrl_q <= ctrl_wr[`CTRL_W-1:0];
        `OFS_EVENT_EN: begin
          if (wstrb_q[0]) event_en_q <= wdata_q[`EVENT_W-1:0];
        end
        `OFS_CMP_VALUE:
          cmp_value_q <= merge(cmp_value_q, wdata_q, wstrb_q);
        `OFS_PULSE_DUR: begin  // Whole 2ms steps only
          if (wstrb_q[0]) pulse_dur_q <= wdata_q[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter and sticky limit flags

  // Next count: a software load wins over a step in the same cycle
  always @* begin
    count_d = count_q;
    if (wr_fire && mapped(awaddr_q) && awaddr_q[5:0] == `OFS_COUNT) begin
      count_d = merge(count_q, wdata_q, wstrb_q);
    end else if (do_step) begin
      count_d = step_up ? count_q + 32'h1 : count_q - 32'h1;
    end
  end

  // Counting wraps at the full signed range
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_q               <= `COUNT_RESET;
      overflow_status_flag  <= 1'b0;
      underflow_status_flag <= 1'b0;
    end else begin
      count_q <= count_d;
      // Set wins over the clear request in the same cycle
      overflow_status_flag  <= oflw |
        (overflow_status_flag & ~wr_status);
      underflow_status_flag <= uflw |
        (underflow_status_flag & ~wr_status);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparator and output

  assign cond = ctrl_q[`F_CMP_LE] ?
    ($signed(count_d) <= $signed(cmp_value_q)) :
    ($signed(count_d) >= $signed(cmp_value_q));
  // Reaching from the main direction only, if one is set
  assign reach = do_step && (count_d == cmp_value_q) &&
    (ctrl_q[`F_MAIN_DIR] == `MAIN_NONE ||
     (ctrl_q[`F_MAIN_DIR] == `MAIN_UP && step_up) ||
     (ctrl_q[`F_MAIN_DIR] == `MAIN_DOWN && !step_up));
  assign pre_wrap = (pre_q == STEP_CYCLES - 1);

  // Pulse timer restarts its prescaler at the pulse start, so the
  // length is exact rather than off by up to one step
  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_run_q  <= 1'b0;
      pulse_left_q <= 8'h00;
      pre_q        <= 19'h0;
      hold_q       <= 1'b0;
    end else if (ctrl_q[`F_OUT_CHAR] != `CHAR_PULSE) begin
      pulse_run_q <= 1'b0;
      hold_q      <= 1'b0;
    end else if (pulse_run_q) begin  // Reaching again is ignored
      pre_q <= pre_wrap ? 19'h0 : pre_q + 19'h1;
      if (pre_wrap) begin
        pulse_left_q <= pulse_left_q - 8'h1;
        if (pulse_left_q == 8'h1) pulse_run_q <= 1'b0;
      end
    end else if (reach && pulse_dur_q != 8'h00) begin
      pulse_run_q  <= 1'b1;
      pulse_left_q <= pulse_dur_q;
      pre_q        <= 19'h0;
    end else begin
      // Zero duration: held while the value still matches
      hold_q <= (reach | hold_q) && (count_d == cmp_value_q)
                && (pulse_dur_q == 8'h00);
    end
  end

  // Output value per characteristic
  always @* begin
    out_d      = 1'b0;
    cmp_flag_d = 1'b0;
    case (ctrl_q[`F_OUT_CHAR])
      `CHAR_NONE: begin
        out_d      = ctrl_q[`F_SW_OUT];
        cmp_flag_d = 1'b0;
      end
      `CHAR_CMP: begin
        out_d      = cond;
        cmp_flag_d = cond;
      end
      `CHAR_PULSE: begin
        out_d      = pulse_run_q | hold_q;
        cmp_flag_d = pulse_run_q | hold_q;
      end
      default: begin
        out_d      = ctrl_q[`F_SW_OUT];
        cmp_flag_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Events and interrupts

  assign ev_open  = event_en_q[`F_EV_OPEN] & software_gate &
                    hardware_gate_input & ~hardware_gate_input_q;
  assign ev_close = event_en_q[`F_EV_CLOSE] & software_gate &
                    ~hardware_gate_input & hardware_gate_input_q;
  assign ev_cmp   = event_en_q[`F_EV_CMP] & cmp_flag_d &
                    ~cmp_prev_q;
  assign proc_event = ev_open | ev_close | ev_cmp |
    (event_en_q[`F_EV_OFLW] & oflw) |
    (event_en_q[`F_EV_UFLW] & uflw);

  // Outputs, edge history and interrupt bookkeeping
  always @(posedge aclk) begin
    if (!aresetn) begin
      digital_out_q       <= 1'b0;
      compare_status_flag <= 1'b0;
      cmp_prev_q          <= 1'b0;
      hardware_gate_input_q           <= 1'b0;
      process_irq_q       <= 1'b0;
      diag_irq_q          <= 1'b0;
      proc_pend_q         <= 1'b0;
    end else begin
      digital_out_q       <= out_d;
      compare_status_flag <= cmp_flag_d;
      cmp_prev_q          <= cmp_flag_d;
      hardware_gate_input_q           <= hardware_gate_input;
      process_irq_q       <= 1'b0;
      diag_irq_q          <= 1'b0;
      if (ctrl_q[`F_IRQ_SEL] == `IRQ_OFF) begin
        proc_pend_q <= 1'b0;
      end else begin
        // A new event wins over an acknowledge in the same cycle
        proc_pend_q   <= proc_event | (proc_pend_q & ~process_irq_ack);
        process_irq_q <= proc_event;
        // Loss: event while the previous one is still untaken
        diag_irq_q    <= proc_event & proc_pend_q & ~process_irq_ack &
                         (ctrl_q[`F_IRQ_SEL] == `IRQ_DIAG);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus read path

  // One read at a time; answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (mapped(s_axi_araddr) ? s_axi_araddr[5:0] : 6'h3f)
        `OFS_CTRL:      s_axi_rdata <= {19'h0, ctrl_q};
        `OFS_EVENT_EN:  s_axi_rdata <= {27'h0, event_en_q};
        `OFS_CMP_VALUE: s_axi_rdata <= cmp_value_q;
        `OFS_PULSE_DUR: s_axi_rdata <= {24'h0, pulse_dur_q};
        `OFS_COUNT:     s_axi_rdata <= count_q;
        `OFS_STATUS:
          s_axi_rdata <= {27'h0, gate_open, digital_out_q,
                          underflow_status_flag, overflow_status_flag,
                          compare_status_flag};
        default:                s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // counter_channel

// ==== tb/enc_src.sv ====
// Pulse/direction and two-track encoder source model
module enc_src (
  // Clock
  input  wire  aclk,
  // Tracks
  output logic track_a,
  output logic track_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines rest low; a real source drives them at all times
  initial {track_a, track_b} = 2'b00;
  // Direction settles one edge before the count pulse
  task automatic pd_step(input logic up);
    @(posedge aclk) track_b <= up;
    @(posedge aclk) track_a <= 1'b1;
    @(posedge aclk) track_a <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  // One track edge in gray order 00,10,11,01 when counting up
  task automatic q_step(input logic up);
    @(posedge aclk);
    if (up) begin
      {track_a, track_b} <= {~track_b, track_a};
    end else begin
      {track_a, track_b} <= {track_b, ~track_a};
    end
    @(posedge aclk);
  endtask
endmodule // enc_src

// ==== tb/counter_channel_assertions.sv ====
// Port-level checks of the counter channel
module counter_channel_assertions #(
  parameter STEP_CYCLES = 8
) (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Output and interrupts
  input wire        digital_out_q,
  input wire        process_irq_q,
  input wire        diag_irq_q,
  input wire        process_irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg pend_q;  // A process interrupt is still untaken
  ////////////////////////////////////////////////////////////////////////
  // Ack wins over a new pulse: a same-cycle ack counts as taken
  always @(posedge aclk) begin
    if (!aresetn) pend_q <= 1'b0;
    else if (process_irq_ack) pend_q <= 1'b0;
    else if (process_irq_q) pend_q <= 1'b1;
  end
  reset_quiet_a: assert property ($rose(aresetn) |-> !digital_out_q &&
    !process_irq_q && !diag_irq_q && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken during response");
  aw_return_a: assert property (s_axi_bvalid && s_axi_bready |=>
    s_axi_awready && s_axi_wready) else $error("write not reopened");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read response late");
  diag_cause_a: assert property (diag_irq_q |-> pend_q)
    else $error("diagnostic without lost interrupt");
endmodule // counter_channel_assertions

bind counter_channel counter_channel_assertions #(
  .STEP_CYCLES(STEP_CYCLES)) chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .digital_out_q(digital_out_q), .process_irq_q(process_irq_q),
  .diag_irq_q(diag_irq_q), .process_irq_ack(process_irq_ack));

// ==== tb/tb.sv ====
// Self-checking bench for the counter channel
`include "counter_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 8;  // Short duration step keeps runs brief
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic        awvalid, wvalid, bready;
  logic        arvalid, rready, hgate, ack;
  logic        awready, wready, bvalid, arready, rvalid, dout, irq, diag;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  wstrb;
  logic        track_a, track_b;
  int          fail_count = 0, n_checks = 0, hi_cnt = 0, irq_n = 0;
  int          diag_n = 0, h0, i0;
  logic [31:0] d;
  always #2 aclk = ~aclk;
  // Running totals of output-high cycles and interrupt pulses
  always @(posedge aclk) begin
    hi_cnt <= hi_cnt + int'(dout === 1'b1);
    irq_n <= irq_n + int'(irq === 1'b1);
    diag_n <= diag_n + int'(diag === 1'b1);
  end
  counter_channel #(.STEP_CYCLES(STEP)) uut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .track_a(track_a), .track_b(track_b),
    .hardware_gate_input(hgate), .digital_out_q(dout),
    .process_irq_q(irq), .diag_irq_q(diag), .process_irq_ack(ack));
  enc_src enc (.aclk(aclk), .track_a(track_a), .track_b(track_b));
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus write; address and data released each when taken
  task automatic wr(input logic [31:0] a, v, input logic [3:0] s = 4'hf);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (i == 50) fail_count++;
    if (i == 50) complete_run();
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (i == 50) fail_count++;
    if (i == 50) complete_run();
  endtask
  // Let the output follow the count before looking at it
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`OFS_CTRL, d);
    chk("ctrl", 32'h0, d);
    wr(`OFS_EVENT_EN, 32'h1f, 4'he);
    rd(`OFS_EVENT_EN, d);
    chk("events", 32'h0, d);
    rd(`OFS_PULSE_DUR, d);
    chk("duration", 32'h0, d);
    rd(32'h20, d);
    chk("unmapped", {30'h0, `RESP_SLVERR}, {d[29:0], resp});
    wr(32'h20, 32'h1);
    chk("unmapped wr", {30'h0, `RESP_SLVERR}, {30'h0, resp});
    $display("reset test done");
  endtask
  task automatic t_pd();
    wr(`OFS_CTRL, 32'h200);
    wr(`OFS_COUNT, 32'h0);
    repeat (3) enc.pd_step(1'b1);
    enc.pd_step(1'b0);
    rd(`OFS_COUNT, d);
    chk("pd count", 32'h2, d);
    wr(`OFS_CTRL, 32'h208);
    enc.pd_step(1'b1);
    rd(`OFS_COUNT, d);
    chk("inverted", 32'h1, d);
    $display("pulse/direction test done");
  endtask
  task automatic t_quad();
    for (int m = 1; m < 4; m++) begin
      wr(`OFS_CTRL, 32'h200 | m);
      wr(`OFS_COUNT, 32'h0);
      repeat (4) enc.q_step(1'b1);
      rd(`OFS_COUNT, d);
      chk("quad up", (m == 3) ? 32'h4 : m, d);
      repeat (4) enc.q_step(1'b0);
      rd(`OFS_COUNT, d);
      chk("quad down", 32'h0, d);
    end
    $display("encoder test done");
  endtask
  task automatic t_cmp();
    wr(`OFS_CTRL, 32'h600);
    rd(`OFS_STATUS, d);
    chk("sw out", 32'h8, d & 32'h9);
    wr(`OFS_CMP_VALUE, 32'h2);
    wr(`OFS_COUNT, 32'h0);
    wr(`OFS_EVENT_EN, 32'h4);
    wr(`OFS_CTRL, 32'ha10);
    i0 = irq_n;
    repeat (2) enc.pd_step(1'b1);
    rd(`OFS_STATUS, d);
    chk("ge hit", 32'h9, d & 32'h9);
    chk("cmp irq", i0 + 1, irq_n);
    wr(`OFS_CTRL, 32'ha50);
    enc.pd_step(1'b1);
    settle(2);
    chk("le miss", 32'h0, dout);
    $display("comparator test done");
  endtask
  task automatic t_pulse();
    wr(`OFS_EVENT_EN, 32'h0);
    wr(`OFS_CTRL, 32'h220);
    wr(`OFS_PULSE_DUR, 32'h2);
    wr(`OFS_CMP_VALUE, 32'h1);
    wr(`OFS_COUNT, 32'h0);
    h0 = hi_cnt;
    enc.pd_step(1'b1);
    enc.pd_step(1'b0);
    enc.pd_step(1'b1);
    settle(40);
    chk("pulse len", 2 * STEP, hi_cnt - h0);
    enc.pd_step(1'b0);
    h0 = hi_cnt;
    enc.pd_step(1'b1);
    wr(`OFS_PULSE_DUR, 32'h1);
    settle(40);
    chk("old length", 2 * STEP, hi_cnt - h0);
    enc.pd_step(1'b0);
    h0 = hi_cnt;
    enc.pd_step(1'b1);
    settle(40);
    chk("new length", STEP, hi_cnt - h0);
    wr(`OFS_PULSE_DUR, 32'h0);
    enc.pd_step(1'b0);
    enc.pd_step(1'b1);
    settle(30);
    chk("zero dur held", 32'h1, dout);
    enc.pd_step(1'b1);
    settle(2);
    chk("zero dur off", 32'h0, dout);
    wr(`OFS_CTRL, 32'h2a0);
    wr(`OFS_PULSE_DUR, 32'h1);
    h0 = hi_cnt;
    enc.pd_step(1'b0);
    settle(30);
    chk("from above", 32'h0, hi_cnt - h0);
    $display("pulse test done");
  endtask
  task automatic t_flow();
    wr(`OFS_CTRL, 32'ha00);
    wr(`OFS_EVENT_EN, 32'h18);
    wr(`OFS_COUNT, `COUNT_MAX);
    i0 = irq_n;
    enc.pd_step(1'b1);
    rd(`OFS_COUNT, d);
    chk("wrap up", `COUNT_MIN, d);
    chk("oflw irq", i0 + 1, irq_n);
    settle(20);
    rd(`OFS_STATUS, d);
    chk("oflw sticky", 32'h2, d & 32'h6);
    wr(`OFS_STATUS, 32'h0);
    rd(`OFS_STATUS, d);
    chk("oflw clear", 32'h0, d & 32'h6);
    enc.pd_step(1'b0);
    rd(`OFS_STATUS, d);
    chk("uflw flag", 32'h4, d & 32'h6);
    chk("uflw irq", i0 + 2, irq_n);
    $display("overflow test done");
  endtask
  task automatic t_gate();
    @(posedge aclk) ack <= 1'b1;
    @(posedge aclk) ack <= 1'b0;
    wr(`OFS_CTRL, 32'h1204);
    wr(`OFS_EVENT_EN, 32'h3);
    wr(`OFS_COUNT, 32'h0);
    i0 = irq_n;
    h0 = diag_n;
    enc.pd_step(1'b1);
    rd(`OFS_COUNT, d);
    chk("gate shut", 32'h0, d);
    @(posedge aclk) hgate <= 1'b1;
    settle(3);
    chk("open irq", i0 + 1, irq_n);
    enc.pd_step(1'b1);
    rd(`OFS_COUNT, d);
    chk("gate open", 32'h1, d);
    @(posedge aclk) hgate <= 1'b0;
    settle(3);
    chk("close irq", i0 + 2, irq_n);
    chk("lost irq", h0 + 1, diag_n);
    $display("gate test done");
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, hgate, ack} <= '0;
    {awaddr, wdata, araddr, wstrb} <= '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_pd();
    t_quad();
    t_cmp();
    t_pulse();
    t_flow();
    t_gate();
    complete_run();
  end
endmodule // tb
